// File: logic/i2csw_consts.svh
// Notes on behaviour
// - any channel combination connects to upstream pair
// - downstream interrupt drives combined interrupt output
// - reset input low resets the state machine
// - any reset deselects every downstream channel
// - slave address includes two address-select pins
// - one 8-bit control register, written or read
// - reject short low and high interrupt pulses
// - interrupt valid within 4 us, cleared within 2 us
// - reset releases upstream data within 500 ns
// - start accepted right after reset release
// - received data held 300 ns past clock fall
// - low control bits enable their channels
// - high control bits report interrupt inputs
// - new selection takes effect at next stop
// - several written bytes keep only the last
`ifndef I2CSW_CONSTS_SVH
`define I2CSW_CONSTS_SVH

`define I2CSW_CLK_PERIOD_NS 4
`define I2CSW_CHANNELS 4
`define I2CSW_CHAN_LSB 0
`define I2CSW_IRQ_LSB 4
`define I2CSW_CTRL_RESET 4'h0
`define I2CSW_BYTE_BITS 4'h8
// address prefix is arbitrary, not taken from any part
`define I2CSW_ADDR_PREFIX 5'h0A
`define I2CSW_HOLD_NS 300
`define I2CSW_HOLD_CYC ((`I2CSW_HOLD_NS + `I2CSW_CLK_PERIOD_NS - 1) / `I2CSW_CLK_PERIOD_NS)
`define I2CSW_LOW_REJ_NS 1000
`define I2CSW_LOW_REJ_CYC ((`I2CSW_LOW_REJ_NS + `I2CSW_CLK_PERIOD_NS - 1) / `I2CSW_CLK_PERIOD_NS)
`define I2CSW_HIGH_REJ_NS 500
`define I2CSW_HIGH_REJ_CYC ((`I2CSW_HIGH_REJ_NS + `I2CSW_CLK_PERIOD_NS - 1) / `I2CSW_CLK_PERIOD_NS)
`define I2CSW_IRQ_VALID_NS 4000
`define I2CSW_IRQ_VALID_CYC (`I2CSW_IRQ_VALID_NS / `I2CSW_CLK_PERIOD_NS)
`define I2CSW_IRQ_CLEAR_NS 2000
`define I2CSW_IRQ_CLEAR_CYC (`I2CSW_IRQ_CLEAR_NS / `I2CSW_CLK_PERIOD_NS)

`endif

// File: logic/i2csw_pkg.sv
package i2csw_pkg;
	typedef logic [3:0] i2csw_chan_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WRITE,
		ST_WRITE_ACK,
		ST_READ,
		ST_READ_ACK
	} i2csw_state_t;
endpackage

// File: logic/i2csw_sync.sv
`timescale 1ns/1ps
module i2csw_sync #(
	parameter int WIDTH = 4
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta;

	// idle-high reset so no false edge appears at release
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '1;
			dout <= '1;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// File: logic/i2csw_irq_filter.sv
`timescale 1ns/1ps
module i2csw_irq_filter #(
	parameter int LOW_CYC = 250,
	parameter int HIGH_CYC = 125
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic din,
	output logic level
);
	localparam int CW = $clog2(LOW_CYC + HIGH_CYC + 1);
	logic [CW-1:0] cnt;
	logic [CW-1:0] run;
	logic din_prev;
	wire [CW-1:0] thresh = level ? CW'(LOW_CYC - 1) : CW'(HIGH_CYC - 1);
	wire differs = din != level;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			level <= 1'b1;
		end
		else if (!differs)
			cnt <= '0;
		else if (cnt == thresh)
		begin
			cnt <= '0;
			level <= din;
		end
		else
			cnt <= cnt + 1'b1;
	end

	// helper for checks: cycles since din last changed
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run <= '0;
			din_prev <= 1'b1;
		end
		else
		begin
			din_prev <= din;
			if (din != din_prev)
				run <= '0;
			else if (run != '1)
				run <= run + 1'b1;
		end
	end

	// run lags the first differing sample by one cycle
	property p_low_reject;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(level) |-> !$past(din) && $past(run) >= CW'(LOW_CYC - 2);
	endproperty
	a_low_reject: assert property (p_low_reject)
		else $error("filtered level fell after a short low pulse");

	property p_high_reject;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(level) |-> $past(din) && $past(run) >= CW'(HIGH_CYC - 2);
	endproperty
	a_high_reject: assert property (p_high_reject)
		else $error("filtered level rose after a short high pulse");

	property p_low_valid;
		@(posedge sys_clk) disable iff (!rst_n)
		(!din && din_prev == din && run == CW'(LOW_CYC - 2) && level) |=> !level;
	endproperty
	a_low_valid: assert property (p_low_valid)
		else $error("long low pulse not taken in time");
endmodule

// File: logic/i2csw_ctrl.sv
`timescale 1ns/1ps
`include "i2csw_consts.svh"
module i2csw_ctrl #(
	parameter logic [4:0] ADDR_PREFIX = `I2CSW_ADDR_PREFIX,
	parameter int HOLD_CYC = `I2CSW_HOLD_CYC,
	parameter int LOW_REJ_CYC = `I2CSW_LOW_REJ_CYC,
	parameter int HIGH_REJ_CYC = `I2CSW_HIGH_REJ_CYC
)(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_select_lo,
	input wire logic addr_select_hi,
	input wire i2csw_pkg::i2csw_chan_t downstream_irq_n,
	output logic irq_out_n,
	output i2csw_pkg::i2csw_chan_t chan_enable
);
	import i2csw_pkg::*;
	localparam int HW = $clog2(HOLD_CYC + 1);
	localparam int HOLD_WIN = 80;
	localparam int IRQ_SET_WIN = 260;
	logic rst_meta, rst_n, scl_s, sda_s, a_hi_s, a_lo_s, scl_prev, sda_int, sda_prev;
	i2csw_chan_t irq_s, filt, pending, next_pend;
	logic [HW-1:0] hold_cnt;
	i2csw_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shift, next_shift, tx, next_tx;
	logic drive_req, next_drive, pend_valid, next_pvalid;

	// reset asserts at once, releases through two flops
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	i2csw_sync #(
		.WIDTH(4 + `I2CSW_CHANNELS)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.din({scl_in, sda_in, addr_select_hi, addr_select_lo, downstream_irq_n}),
		.dout({scl_s, sda_s, a_hi_s, a_lo_s, irq_s})
	);

	genvar gi;
	generate
		for (gi = 0; gi < `I2CSW_CHANNELS; gi++)
		begin : g_filt
			i2csw_irq_filter #(
				.LOW_CYC(LOW_REJ_CYC),
				.HIGH_CYC(HIGH_REJ_CYC)
			) u_filt (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.din(irq_s[gi]),
				.level(filt[gi])
			);
		end
	endgenerate
	wire scl_rise = scl_s & ~scl_prev;
	wire scl_fall = ~scl_s & scl_prev;
	wire start_det = scl_s & scl_prev & sda_prev & ~sda_int;
	wire stop_det = scl_s & scl_prev & ~sda_prev & sda_int;
	wire hold_active = scl_fall | (hold_cnt != '0);
	wire byte_done = cnt == `I2CSW_BYTE_BITS;
	// address bits from the select pins
	wire addr_match = shift[7:1] == {ADDR_PREFIX, a_hi_s, a_lo_s};
	// high nibble reads 1 for an asserted input
	wire [7:0] read_byte = {~filt, chan_enable};

	// internal data and our output are frozen after scl falls
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_prev <= 1'b1;
			sda_int <= 1'b1;
			sda_prev <= 1'b1;
			hold_cnt <= '0;
		end
		else
		begin
			scl_prev <= scl_s;
			sda_prev <= sda_int;
			if (!hold_active)
				sda_int <= sda_s;
			if (scl_fall)
				hold_cnt <= HW'(HOLD_CYC - 1);
			else if (hold_cnt != '0)
				hold_cnt <= hold_cnt - 1'b1;
		end
	end

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_shift = shift;
		next_tx = tx;
		next_drive = drive_req;
		next_pend = pending;
		next_pvalid = pend_valid;
		// a start is taken in any state
		if (start_det)
		begin
			next_state = ST_ADDR;
			next_cnt = 4'h0;
			next_drive = 1'b0;
		end
		else if (stop_det)
		begin
			next_state = ST_IDLE;
			next_drive = 1'b0;
			next_pvalid = 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
					next_drive = 1'b0;
				ST_ADDR:
					if (scl_rise)
					begin
						next_shift = {shift[6:0], sda_int};
						next_cnt = cnt + 4'h1;
					end
					else if (scl_fall && byte_done)
					begin
						next_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
						next_drive = addr_match;
					end
				// address acked, then control bytes written or read
				ST_ADDR_ACK:
					if (scl_fall)
					begin
						next_cnt = 4'h0;
						if (shift[0])
						begin
							next_state = ST_READ;
							next_tx = read_byte;
							next_drive = ~read_byte[7];
						end
						else
						begin
							next_state = ST_WRITE;
							next_drive = 1'b0;
						end
					end
				ST_WRITE:
					if (scl_rise)
					begin
						next_shift = {shift[6:0], sda_int};
						next_cnt = cnt + 4'h1;
					end
					// each byte overwrites the pending value
					else if (scl_fall && byte_done)
					begin
						next_pend = shift[`I2CSW_CHAN_LSB +: `I2CSW_CHANNELS];
						next_pvalid = 1'b1;
						next_state = ST_WRITE_ACK;
						next_drive = 1'b1;
					end
				ST_WRITE_ACK:
					if (scl_fall)
					begin
						next_state = ST_WRITE;
						next_cnt = 4'h0;
						next_drive = 1'b0;
					end
				ST_READ:
					if (scl_rise)
						next_cnt = cnt + 4'h1;
					else if (scl_fall)
					begin
						if (byte_done)
						begin
							next_state = ST_READ_ACK;
							next_drive = 1'b0;
						end
						else
						begin
							next_tx = {tx[6:0], 1'b0};
							next_drive = ~tx[6];
						end
					end
				// master ack repeats the byte, nack releases the line
				ST_READ_ACK:
					if (scl_rise)
						next_shift = {shift[6:0], sda_int};
					else if (scl_fall)
					begin
						next_cnt = 4'h0;
						if (!shift[0])
						begin
							next_state = ST_READ;
							next_tx = read_byte;
							next_drive = ~read_byte[7];
						end
						else
						begin
							next_state = ST_IDLE;
							next_drive = 1'b0;
						end
					end
				default:
				begin
					next_state = ST_IDLE;
					next_drive = 1'b0;
				end
			endcase
		end
	end

	// state machine cleared by either reset
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			drive_req <= 1'b0;
			pending <= `I2CSW_CTRL_RESET;
			pend_valid <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			shift <= next_shift;
			tx <= next_tx;
			drive_req <= next_drive;
			pending <= next_pend;
			pend_valid <= next_pvalid;
		end
	end

	// selection applied only at stop, zero after reset
	// combined interrupt; data line released under reset
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_enable <= `I2CSW_CTRL_RESET;
			irq_out_n <= 1'b1;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			if (stop_det && pend_valid)
				chan_enable <= pending;
			irq_out_n <= &filt;
			if (!hold_active)
				sda_oe <= drive_req;
			sda_out <= 1'b0;
		end
	end
	sequence s_addr_hit;
		state == ST_ADDR && scl_fall && byte_done && addr_match && !start_det && !stop_det;
	endsequence
	sequence s_drive_low;
		##[1:HOLD_WIN] sda_oe;
	endsequence
	property p_addr_ack;
		@(posedge sys_clk) disable iff (!rst_n)
		s_addr_hit |-> s_drive_low;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address was not acknowledged");
	property p_chan_stop;
		@(posedge sys_clk) disable iff (!rst_n)
		$changed(chan_enable) |-> $past(stop_det) && $past(pend_valid);
	endproperty
	a_chan_stop: assert property (p_chan_stop)
		else $error("channel selection changed without a stop");
	property p_last_byte;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_WRITE && scl_fall && byte_done && !start_det && !stop_det)
			|=> pending == $past(shift[3:0]) && pend_valid;
	endproperty
	a_last_byte: assert property (p_last_byte)
		else $error("written byte not kept as pending selection");
	property p_reset_clear;
		@(posedge sys_clk)
		$rose(rst_n) |-> chan_enable == 4'h0 && state == ST_IDLE && !sda_oe;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("channels or state not cleared by reset");
	property p_sda_release;
		@(posedge sys_clk)
		!rst_n |-> !sda_oe;
	endproperty
	a_sda_release: assert property (p_sda_release)
		else $error("data line driven during reset");
	property p_start_accept;
		@(posedge sys_clk) disable iff (!rst_n)
		start_det |=> state == ST_ADDR && cnt == 4'h0;
	endproperty
	a_start_accept: assert property (p_start_accept)
		else $error("start condition not accepted");
	// window length follows HOLD_CYC, so no fixed repeat count
	property p_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		hold_active |=> $stable(sda_oe) && $stable(sda_int);
	endproperty
	a_hold: assert property (p_hold)
		else $error("data changed inside the hold window");
	property p_irq_and;
		@(posedge sys_clk) disable iff (!rst_n)
		##1 irq_out_n == &$past(filt);
	endproperty
	a_irq_and: assert property (p_irq_and)
		else $error("combined interrupt not the AND of inputs");
	property p_irq_set;
		@(posedge sys_clk) disable iff (!rst_n)
		($fell(irq_s[0]) ##1 !irq_s[0] [*8]) |-> ##[1:IRQ_SET_WIN] (!irq_out_n || irq_s[0]);
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("interrupt output late after input asserted");
	property p_read_byte;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_ADDR_ACK && scl_fall && shift[0] && !start_det && !stop_det)
			|=> tx == {~$past(filt), $past(chan_enable)};
	endproperty
	a_read_byte: assert property (p_read_byte)
		else $error("read byte does not show interrupts and channels");
endmodule

// File: dv/i2csw_master.sv
`timescale 1ns/1ps
// upstream bus master; scl stands high between frames
module i2csw_master (
	input wire logic sys_clk,
	input wire logic sda_bus,
	output logic scl,
	output logic sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic start();
		sda_drv = 1'b1;
		cyc(3);
		scl = 1'b1;
		cyc(4);
		sda_drv = 1'b0;
		cyc(4);
		scl = 1'b0;
		cyc(1);
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		cyc(3);
		scl = 1'b1;
		cyc(4);
		sda_drv = 1'b1;
		cyc(6);
	endtask
	// low time long, so the slave's delayed data settles before scl rises
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		cyc(5);
		scl = 1'b1;
		cyc(1);
		r = sda_bus;
		cyc(1);
		scl = 1'b0;
		cyc(1);
	endtask
	// same master selects and uses channels
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "i2csw_consts.svh"
module testbench;
	import i2csw_pkg::*;
	localparam int LOW_CYC = `I2CSW_LOW_REJ_CYC;
	localparam int HIGH_CYC = `I2CSW_HIGH_REJ_CYC;
	localparam logic [4:0] PFX = `I2CSW_ADDR_PREFIX;
	logic sys_clk;
	logic resetn;
	logic scl;
	logic sda_drv;
	logic sda_oe;
	logic sda_out;
	logic addr_select_lo;
	logic addr_select_hi;
	logic irq_out_n;
	logic ack;
	logic [7:0] v;
	logic [7:0] q[$];
	i2csw_chan_t irq_n;
	i2csw_chan_t chan_enable;
	wire sda_bus;
	int fail_count;
	int cmp_count;
	int model_chan;
	// open drain: the pin shows sda_out only while enabled, else the pull-up
	assign sda_bus = sda_drv & (sda_oe ? sda_out : 1'b1);
	// short hold so the 32 ns bench link period fits
	i2csw_ctrl #(.HOLD_CYC(1)) dut (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.scl_in(scl),
		.sda_in(sda_bus),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.addr_select_lo(addr_select_lo),
		.addr_select_hi(addr_select_hi),
		.downstream_irq_n(irq_n),
		.irq_out_n(irq_out_n),
		.chan_enable(chan_enable)
	);
	i2csw_master mst (.sys_clk(sys_clk), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv));
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
		logic k;
		logic m;
		m = (a == {PFX, addr_select_hi, addr_select_lo});
		mst.start();
		mst.wr_byte({a, 1'b0}, k);
		chk("addr_ack", {7'h00, m}, {7'h00, k});
		if (k)
		begin
			foreach (d[i])
				mst.wr_byte(d[i], k);
			chk("data_ack", 8'h01, {7'h00, k});
			chk("pending", model_chan[7:0], {4'h0, chan_enable});
			model_chan = d[d.size() - 1][3:0];
		end
		mst.stop();
		chk("chan", model_chan[7:0], {4'h0, chan_enable});
	endtask
	task automatic rd_chk(input i2csw_chan_t st);
		logic k;
		logic [7:0] d;
		mst.start();
		mst.wr_byte({PFX, addr_select_hi, addr_select_lo, 1'b1}, k);
		mst.rd_byte(1'b0, d);
		chk("read", {st, model_chan[3:0]}, d);
		mst.rd_byte(1'b1, d);
		mst.stop();
		chk("reread", {st, model_chan[3:0]}, d);
	endtask
	task automatic wait_irq(input logic lvl, input int n);
		int i;
		for (i = 0; i < n && irq_out_n !== lvl; i++)
			mst.cyc(1);
		chk("irq_out_n", {7'h00, lvl}, {7'h00, irq_out_n});
	endtask
	task automatic irq_chk(input int ch);
		irq_n[ch] = 1'b0;
		mst.cyc(LOW_CYC - 3);
		irq_n[ch] = 1'b1;
		mst.cyc(LOW_CYC + 6);
		chk("irq_short_lo", 8'h01, {7'h00, irq_out_n});
		irq_n[ch] = 1'b0;
		wait_irq(1'b0, LOW_CYC + 6);
		rd_chk(~irq_n);
		irq_n[ch] = 1'b1;
		mst.cyc(HIGH_CYC - 2);
		irq_n[ch] = 1'b0;
		mst.cyc(HIGH_CYC + 6);
		chk("irq_short_hi", 8'h00, {7'h00, irq_out_n});
		irq_n[ch] = 1'b1;
		wait_irq(1'b1, HIGH_CYC + 6);
	endtask
	initial
	begin
		#200000;
		fail_count++;
		$display("MISMATCH watchdog expected done seen hang");
		stop_test();
	end
	initial
	begin
		fail_count = 0;
		cmp_count = 0;
		model_chan = 0;
		resetn = 1'b0;
		irq_n = 4'hF;
		addr_select_lo = 1'b0;
		addr_select_hi = 1'b0;
		void'($urandom(99785));
		// reset held far past 6 ns
		mst.cyc(6);
		chk("idle", 8'h10, {2'h0, sda_oe, irq_out_n, chan_enable});
		resetn = 1'b1;
		mst.cyc(4);
		for (int s = 0; s < 4; s++)
		begin
			{addr_select_hi, addr_select_lo} = s[1:0];
			mst.cyc(4);
			v = $urandom;
			q = {v};
			wr({PFX, s[1:0] ^ 2'h1}, q);
			wr({PFX, s[1:0]}, q);
		end
		for (int c = 0; c < 16; c++)
		begin
			v = $urandom;
			q = {v, {v[7:4], c[3:0]}};
			wr({PFX, addr_select_hi, addr_select_lo}, q);
			rd_chk(4'h0);
		end
		mst.start();
		mst.wr_byte({PFX, addr_select_hi, addr_select_lo, 1'b1}, ack);
		mst.cyc(6);
		chk("drive", 8'h01, {7'h00, sda_oe});
		resetn = 1'b0;
		mst.cyc(1);
		chk("rst_mid", 8'h10, {2'h0, sda_oe, irq_out_n, chan_enable});
		mst.stop();
		model_chan = 0;
		resetn = 1'b1;
		mst.cyc(4);
		rd_chk(4'h0);
		q = {8'h05};
		wr({PFX, addr_select_hi, addr_select_lo}, q);
		for (int ch = 0; ch < 4; ch++)
			irq_chk(ch);
		irq_n = 4'($urandom_range(14, 0));
		mst.cyc(LOW_CYC + 8);
		chk("irq_and", 8'h00, {7'h00, irq_out_n});
		rd_chk(~irq_n);
		irq_n = 4'hF;
		wait_irq(1'b1, HIGH_CYC + 6);
		stop_test();
	end
endmodule
